// File: hw/sbtc_timer.v
// 16-bit timer/counter with control, period, status and mask registers
// the count holds the period for one tick, then wraps to zero
// assumes an apb master on pclk; ext_clk_pin and gate_pin are async pins
//
// Added by the designer: the APB register port and the address map.
`include "sbtc_regs.vh"
// Operation
// [R01] the run bit starts the counter when one and stops it when zero.
// [R02] with idle stop set the timer halts in idle, else keeps running.
// [R03] gating applies only with the internal source selected.
// [R04] the prescale field divides by 1, 8, 64 or 256.
// [R05] with external source, sync select chooses synchronised counting.
// [R06] sync select is ignored while the internal source is used.
// [R07] clock source one counts external rising edges, zero counts pclk.
// [R08] unimplemented control bits read zero and ignore writes.
// [R09] all control bits reset to zero.
// [R10] period match and gate falling edge raise the interrupt request.
// [R11] timer, synchronous counter and asynchronous counter modes exist.
// [R12] software loads the period before relying on a match.
// [R13] the timer can run in idle or sleep subject to idle stop.
// [R14] the count increments per tick and wraps to zero after a match.
// [R15] gated mode advances only while the gate input is high.
module sbtc_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire cpu_idle,
    input wire ext_clk_pin,
    input wire gate_pin,
    output reg irq
);
    // software-visible registers
    reg [15:0] ctrl_r;
    reg [15:0] count_r;
    reg [15:0] period_r;
    reg [1:0] status_r;
    reg [1:0] mask_r;
    // counter and pin history state
    reg matched_r;
    reg ext_prev_r;
    reg gate_prev_r;
    reg araw1_r;
    reg araw2_r;
    reg araw_prev_r;
    // pin levels, ticks and bus decode
    wire ext_sync;
    wire gate_sync;
    wire ps_tick;
    wire run;
    wire src_ext;
    wire gate_on;
    wire wr;
    wire rd;
    wire addr_ok;
    wire ctrl_wr;
    wire cnt_wr;
    wire ext_rise_s;
    wire ext_rise_a;
    wire in_tick;
    wire idle_halt;
    wire match_evt;
    wire gate_fall;
    wire [1:0] evt;
    wire [1:0] st_set;
    wire [1:0] st_clr;
    wire [1:0] status_nxt;
    reg [1:0] mode;
    reg mode_tick;
    reg [31:0] rdata_nxt;

    // tick source modes
    localparam MODE_TIMER = 2'b00;
    localparam MODE_SYNC = 2'b01;
    localparam MODE_ASYNC = 2'b10;

    assign run = ctrl_r[`SBTC_BIT_RUN];
    // [R03] gate honoured only on internal clock
    assign src_ext = ctrl_r[`SBTC_BIT_SRC];
    assign gate_on = ctrl_r[`SBTC_BIT_GATE] & ~src_ext;

    // filtered pin levels; both pins pass three flops and a level
    // counts once the last two stages agree
    sbtc_insync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_clk_pin),
        .level_r(ext_sync)
    );
    sbtc_insync u_gate_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(gate_pin),
        .level_r(gate_sync)
    );

    // unfiltered path used when synchronisation is off; it still
    // samples on pclk, so a pin edge is seen one to two clocks late
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            araw1_r <= 1'b0;
            araw2_r <= 1'b0;
            araw_prev_r <= 1'b0;
        end else begin
            araw1_r <= ext_clk_pin;
            araw2_r <= araw1_r;
            araw_prev_r <= araw2_r;
        end
    end

    // previous filtered levels for edge detection; reset to the idle
    // low level of both pins so no false edge follows reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_r <= 1'b0;
            gate_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= ext_sync;
            gate_prev_r <= gate_sync;
        end
    end

    // [R07] rising edges of the external pin
    assign ext_rise_s = ext_sync & ~ext_prev_r;
    assign ext_rise_a = araw2_r & ~araw_prev_r;

    // [R11] mode from clock source and sync select
    // [R05] sync select picks filtered or fast path
    // [R06] sync select unused on internal source
    always @* begin
        mode = MODE_TIMER;
        if (src_ext) begin
            if (ctrl_r[`SBTC_BIT_SYNC]) begin
                mode = MODE_SYNC;
            end else begin
                mode = MODE_ASYNC;
            end
        end
    end

    // [R15] tick source per mode; gated timer needs gate high
    always @* begin
        case (mode)
            MODE_TIMER: mode_tick = ~gate_on | gate_sync;
            MODE_SYNC: mode_tick = ext_rise_s;
            MODE_ASYNC: mode_tick = ext_rise_a;
            default: mode_tick = 1'b0;
        endcase
    end
    assign in_tick = mode_tick;

    // [R02] idle stop blocks ticks while the core idles
    assign idle_halt = cpu_idle & ctrl_r[`SBTC_BIT_IDLE_STOP];

    // [R04] prescaler, cleared while stopped
    sbtc_prescale u_ps (
        .pclk(pclk),
        .presetn(presetn),
        .clear(~run),
        .in_tick(in_tick & ~idle_halt),
        .ratio(ctrl_r[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO]),
        .out_tick_r(ps_tick)
    );

    // apb decode; zero wait states
    // rd marks the setup cycle of a read, when read data is loaded
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    // unmapped offsets answer with an error and change nothing
    assign addr_ok = (paddr == `SBTC_OFS_CTRL) ||
                     (paddr == `SBTC_OFS_COUNT) ||
                     (paddr == `SBTC_OFS_PERIOD) ||
                     (paddr == `SBTC_OFS_STATUS) ||
                     (paddr == `SBTC_OFS_MASK);
    assign ctrl_wr = wr & (paddr == `SBTC_OFS_CTRL);
    assign cnt_wr = wr & (paddr == `SBTC_OFS_COUNT);

    // [R10] match and gate falling-edge events
    // a held match is flagged once, not again on the wrap tick
    assign match_evt = run & ps_tick & (count_r == period_r) & ~matched_r;
    assign gate_fall = run & gate_on & gate_prev_r & ~gate_sync;
    assign evt = {gate_fall, match_evt};

    // control register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // [R09] control resets to zero
            ctrl_r <= `SBTC_CTRL_RST;
        end else if (ctrl_wr) begin
            // [R08] unimplemented bits masked
            // [R01] run bit write
            ctrl_r <= pwdata[15:0] & `SBTC_CTRL_MASK;
        end
    end

    // period register; software loads it before relying on a match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_r <= `SBTC_PERIOD_RST;
        end else if (wr & (paddr == `SBTC_OFS_PERIOD)) begin
            period_r <= pwdata[15:0];
        end
    end

    // interrupt mask, same layout as status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 2'b00;
        end else if (wr & (paddr == `SBTC_OFS_MASK)) begin
            mask_r <= pwdata[1:0];
        end
    end

    // count register; a software write wins over a tick in the same
    // cycle and clears any pending wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
            matched_r <= 1'b0;
        end else if (cnt_wr) begin
            count_r <= pwdata[15:0];
            matched_r <= 1'b0;
        end else if (run & ps_tick) begin
            // [R14] increment, wrap after match
            // [R13] keeps counting in idle unless idle stop gates ticks
            if (matched_r) begin
                count_r <= 16'h0000;
                matched_r <= 1'b0;
            end else if (count_r == period_r) begin
                matched_r <= 1'b1;
            end else begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    // set and write-one-to-clear strobes of the status bits
    assign st_set = evt;
    assign st_clr = {2{wr & (paddr == `SBTC_OFS_STATUS)}} & pwdata[1:0];

    // per-bit next status; set wins over a clear in the same cycle so
    // an event is never lost to a racing acknowledge
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_status
            assign status_nxt[gi] = st_set[gi] | (status_r[gi] & ~st_clr[gi]);
        end
    endgenerate

    // sticky status register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 2'b00;
        end else begin
            status_r <= status_nxt;
        end
    end

    // read mux
    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `SBTC_OFS_CTRL: rdata_nxt[15:0] = ctrl_r;
            `SBTC_OFS_COUNT: rdata_nxt[15:0] = count_r;
            `SBTC_OFS_PERIOD: rdata_nxt[15:0] = period_r;
            `SBTC_OFS_STATUS: rdata_nxt[1:0] = status_r;
            `SBTC_OFS_MASK: rdata_nxt[1:0] = mask_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // registered apb answer: ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    // read data loaded in the setup cycle and held until the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd) begin
            prdata <= rdata_nxt;
        end
    end

    // level interrupt; fresh events count so it needs no extra cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_r | evt) & mask_r);
        end
    end
endmodule

// File: hw/sbtc_regs.vh
// register offsets, field positions and reset values of the timer block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef SBTC_REGS_VH
`define SBTC_REGS_VH
`define SBTC_OFS_CTRL 12'h000
`define SBTC_OFS_COUNT 12'h004
`define SBTC_OFS_PERIOD 12'h008
`define SBTC_OFS_STATUS 12'h00C
`define SBTC_OFS_MASK 12'h010
`define SBTC_BIT_RUN 15
`define SBTC_BIT_IDLE_STOP 13
`define SBTC_BIT_GATE 6
`define SBTC_BIT_PS_HI 5
`define SBTC_BIT_PS_LO 4
`define SBTC_BIT_SYNC 2
`define SBTC_BIT_SRC 1
`define SBTC_CTRL_MASK 16'hA076
`define SBTC_CTRL_RST 16'h0000
`define SBTC_PERIOD_RST 16'hFFFF
`define SBTC_ST_MATCH 0
`define SBTC_ST_GATE 1
`define SBTC_PS_DIV8 8'h07
`define SBTC_PS_DIV64 8'h3F
`define SBTC_PS_DIV256 8'hFF
`endif

// File: hw/sbtc_insync.v
// three-stage synchroniser with agreement filter for a pin input
// assumes the pin is asynchronous to pclk
module sbtc_insync (
    input wire pclk,
    input wire presetn,
    input wire pin,
    output reg level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    // stage chain; level updates when stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// File: hw/sbtc_prescale.v
// input clock prescaler: counts enable ticks, emits one tick per ratio
// assumes clear is pulsed when the ratio or source changes
`include "sbtc_regs.vh"
module sbtc_prescale (
    input wire pclk,
    input wire presetn,
    input wire clear,
    input wire in_tick,
    input wire [1:0] ratio,
    output reg out_tick_r
);
    reg [7:0] cnt_r;
    reg [7:0] lim;
    // terminal count for the selected ratio
    always @* begin
        case (ratio)
            2'b01: lim = `SBTC_PS_DIV8;
            2'b10: lim = `SBTC_PS_DIV64;
            2'b11: lim = `SBTC_PS_DIV256;
            default: lim = 8'h00;
        endcase
    end
    // divide counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            out_tick_r <= 1'b0;
        end else if (clear) begin
            cnt_r <= 8'h00;
            out_tick_r <= 1'b0;
        end else begin
            out_tick_r <= 1'b0;
            if (in_tick) begin
                if (cnt_r >= lim) begin
                    cnt_r <= 8'h00;
                    out_tick_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end
endmodule

// File: bench/sbtc_timer_chk.sv
// checker of the timer's apb answers, control readback and interrupt
// assumes a bind to sbtc_timer; sees its ports only
`include "sbtc_regs.vh"
module sbtc_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic irq
);
timeunit 1ns;
timeprecision 1ns;
logic [15:0] ctl_r, msk_r, cnt_r;
logic cnt_ok_r;
wire rd = pready && !pwrite && !pslverr;
wire wr = pready && pwrite && !pslverr;
wire on_ctl = paddr == `SBTC_OFS_CTRL;
wire on_cnt = paddr == `SBTC_OFS_COUNT;
wire wr_cc = wr && (on_ctl || on_cnt);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// shadows of control, mask and the last count read
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_r <= 16'h0000;
        msk_r <= 16'h0000;
        cnt_r <= 16'h0000;
        cnt_ok_r <= 1'b0;
    end else begin
        if (wr && on_ctl) ctl_r <= pwdata[15:0];
        if (wr && paddr == `SBTC_OFS_MASK) msk_r <= pwdata[15:0];
        if (rd && on_cnt) cnt_r <= prdata[15:0];
        cnt_ok_r <= (rd && on_cnt) || (cnt_ok_r && !wr_cc);
    end
end
// apb answer timing and refusals
setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read not zero");
// register contents
ctrl_readback_a: assert property (
    rd && on_ctl |-> prdata == {16'h0000, ctl_r & `SBTC_CTRL_MASK})
    else $error("control readback differs");
upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
count_hold_a: assert property (
    rd && on_cnt && cnt_ok_r && !ctl_r[`SBTC_BIT_RUN] |->
    prdata[15:0] == cnt_r) else $error("stopped count moved");
// interrupt output against the mask
irq_masked_a: assert property (msk_r == 0 && $past(msk_r) == 0 |-> !irq)
    else $error("irq with empty mask");
irq_cause_a: assert property ($rose(irq) |-> $past(msk_r) != 0)
    else $error("irq rose while masked");
// main scenarios reached
cover property (rd && on_cnt && cnt_ok_r);
cover property ($rose(irq));
cover property (pready && pslverr);
endmodule
bind sbtc_timer sbtc_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

// File: bench/tb.sv
// self-checking bench for the timer: apb tasks and counting runs
// assumes hw/ on the include path and the checker bound to the design
`include "sbtc_regs.vh"
module tb;
timeunit 1ns;
timeprecision 1ns;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
logic pwrite = 1'b0, cpu_idle = 1'b0, ext_clk_pin = 1'b0;
logic gate_pin = 1'b0, err_v;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, rd_v;
wire [31:0] prdata;
wire pready, pslverr, irq;
int fails = 0, samples_checked = 0, cyc = 0;
sbtc_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_idle, .ext_clk_pin,
    .gate_pin, .irq);
// 20 MHz clock
always #25 pclk = ~pclk;
// cycle ceiling; external pin toggles every 4 clocks
always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0)
        ext_clk_pin <= ~ext_clk_pin;
    if (cyc == 40000) begin
        fails = fails + 1;
        tally_and_finish();
    end
end
// one apb transfer, then one idle clock
task automatic bus(input bit w, input logic [11:0] a,
        input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        fails++;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
endtask
// count within a window for start and stop latency
task automatic chkr(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
        fails++;
        $display("wrong value at %0t got %h exp %h", $time, got, hi);
    end
endtask
// count for 1024 clocks under ctl, then stop and read twice
task automatic run(input logic [15:0] ctl, input logic idle,
        input logic gate, input int e);
    cpu_idle <= idle;
    gate_pin <= gate;
    bus(1, `SBTC_OFS_COUNT, 32'h0);
    bus(1, `SBTC_OFS_CTRL, {16'h0, ctl});
    repeat (1021) @(posedge pclk);
    bus(1, `SBTC_OFS_CTRL, {16'h0, ctl & 16'h7FFF});
    bus(0, `SBTC_OFS_COUNT, 32'h0);
    bus(0, `SBTC_OFS_COUNT, 32'h0);
    chkr(rd_v, e > 3 ? e - 3 : 0, e + (e > 0));
    $display("run %h done", ctl);
endtask
task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// main sequence
initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, `SBTC_OFS_CTRL, 32'h0);
    chk(rd_v, 32'h0);
    bus(1, `SBTC_OFS_CTRL, 32'hFFFFFFFF);
    bus(0, `SBTC_OFS_CTRL, 32'h0);
    chk(rd_v, 32'h0000A076);
    bus(1, `SBTC_OFS_CTRL, 32'h0);
    bus(0, 12'h020, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    $display("register test done");
    run(16'h8000, 1'b0, 1'b0, 1024);
    run(16'h8010, 1'b0, 1'b0, 128);
    run(16'h8020, 1'b0, 1'b0, 16);
    run(16'h8030, 1'b0, 1'b0, 4);
    run(16'h8004, 1'b0, 1'b0, 1024);
    run(16'h8002, 1'b0, 1'b0, 128);
    run(16'h8006, 1'b0, 1'b0, 128);
    run(16'h8012, 1'b0, 1'b0, 16);
    run(16'hA000, 1'b1, 1'b0, 0);
    run(16'h8000, 1'b1, 1'b0, 1024);
    run(16'h8040, 1'b0, 1'b0, 0);
    run(16'h8040, 1'b0, 1'b1, 1024);
    run(16'h8042, 1'b0, 1'b0, 128);
    bus(1, `SBTC_OFS_PERIOD, 32'h9);
    bus(1, `SBTC_OFS_MASK, 32'h1);
    bus(1, `SBTC_OFS_COUNT, 32'h0);
    bus(1, `SBTC_OFS_CTRL, 32'h8000);
    for (int n = 0; n < 64 && irq !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    bus(0, `SBTC_OFS_COUNT, 32'h0);
    chkr(rd_v, 0, 9);
    bus(1, `SBTC_OFS_CTRL, 32'h0);
    bus(1, `SBTC_OFS_STATUS, 32'h1);
    bus(0, `SBTC_OFS_STATUS, 32'h0);
    chk({30'h0, rd_v[0], irq}, 32'h0);
    bus(1, `SBTC_OFS_MASK, 32'h2);
    gate_pin <= 1'b1;
    bus(1, `SBTC_OFS_CTRL, 32'h8040);
    repeat (10) @(posedge pclk);
    gate_pin <= 1'b0;
    repeat (12) @(posedge pclk);
    bus(0, `SBTC_OFS_STATUS, 32'h0);
    chk({30'h0, rd_v[1], irq}, 32'h3);
    $display("interrupt test done");
    tally_and_finish();
end
endmodule
